// [rtl/mcic_top.sv]
`timescale 1ns/1ps
// ****************************************
// Per-processor interrupt controller
// ****************************************
module mcic_top
    import mcic_pkg::*;
#(
    parameter int NEST_DEPTH = 4
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // Wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    // Upper flag pins, request inputs (active low)
    input  wire logic [3:0]  UPPER_FLAG_PINS_IN,
    output logic      [3:0]  UPPER_FLAG_PINS_OUT,
    output logic      [3:0]  UPPER_FLAG_PINS_OE,
    // Flag lines zero to two, mode pins in reset
    input  wire logic [2:0]  FLAG_LINE_IN,
    output logic      [2:0]  FLAG_LINE_OUT,
    output logic      [2:0]  FLAG_LINE_OE,
    // Serial port one pins used as alternate requests
    input  wire logic        ALT_REQUEST_ONE_N,
    input  wire logic        ALT_REQUEST_ZERO_N,
    // On-chip request pulses
    input  wire logic        TIMER_REQ,
    input  wire logic        BYTE_DMA_PORT_REQ,
    input  wire logic        SERIAL_PORT_ZERO_TX_REQ,
    input  wire logic        SERIAL_PORT_ZERO_RX_REQ,
    input  wire logic        SERIAL_PORT_ONE_TX_REQ,
    input  wire logic        SERIAL_PORT_ONE_RX_REQ,
    input  wire logic        POWER_DOWN_REQ,
    // Toward the sequencer
    output logic             IRQ,
    output logic      [15:0] VECTOR,
    output logic      [3:0]  LEVEL,
    output logic             IDLE,
    output logic             HOST_MODE
);

    // ****************************************
    // Declarations
    // ****************************************
    localparam int NW = $clog2(NEST_DEPTH + 1);

    logic [3:0]         upper_sync;
    logic [2:0]         low_sync;
    logic [1:0]         alt_sync;
    logic [3:0]         upper_prev;
    logic [1:0]         alt_prev;
    logic               ext_request_two;
    logic               level_request_one;
    logic               level_request_zero;
    logic               edge_request;
    logic               alt_request_one;
    logic               alt_request_zero;
    logic [NUM_LVL-1:0] raw;
    logic [NUM_LVL-1:0] status;
    logic [NUM_LVL-1:0] interrupt_mask_reg;
    logic [NUM_LVL-1:0] force_set;
    logic [NUM_LVL-1:0] clr_hit;
    logic [NUM_LVL-1:0] eff;
    logic [NUM_LVL-1:0] pend;
    logic [CTL_W-1:0]   ctrl;
    logic [7:0]         mode_status_reg;
    logic [2:0]         boot_cfg;
    logic [15:0]        flag_reg;
    logic [NW-1:0]      nest;
    logic [3:0]         next_level;
    logic               next_hit;
    logic [15:0]        next_vector;
    logic [31:0]        rd_data;
    logic [31:0]        wmask;
    logic               acc;
    logic               wr;
    logic               rd_unused;

    // ****************************************
    // Bus strobes
    // ****************************************
    // One answer per request; ack drops the cycle after it rose
    assign acc   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign wr    = acc & WB_WE_I;
    assign wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                    {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    assign rd_unused = acc & ~WB_WE_I;

    // Byte-lane merge of a write into a stored value
    function automatic logic [31:0] merge(input logic [31:0] old);
        merge = (old & ~wmask) | (WB_DAT_I & wmask);
    endfunction : merge

    // ****************************************
    // Pin synchronisers
    // ****************************************
    mcic_sync #(.W(4)) u_sync_upper (
        .clk (CLK),
        .d   (UPPER_FLAG_PINS_IN),
        .q   (upper_sync)
    );

    mcic_sync #(.W(3)) u_sync_low (
        .clk (CLK),
        .d   (FLAG_LINE_IN),
        .q   (low_sync)
    );

    mcic_sync #(.W(2)) u_sync_alt (
        .clk (CLK),
        .d   ({ALT_REQUEST_ONE_N, ALT_REQUEST_ZERO_N}),
        .q   (alt_sync)
    );

    // Pin level decides, so a flag driven low by us also interrupts
    assign ext_request_two    = ~upper_sync[3];
    assign level_request_one  = ~upper_sync[2];
    assign level_request_zero = ~upper_sync[1];
    assign edge_request       = ~upper_sync[0];
    assign alt_request_one    = ~alt_sync[1];
    assign alt_request_zero   = ~alt_sync[0];

    // Previous request levels for edge detection
    always_ff @(posedge CLK) begin
        if (RST) begin
            upper_prev <= 4'h0;
            alt_prev   <= 2'h0;
        end else begin
            upper_prev <= {ext_request_two, level_request_one,
                           level_request_zero, edge_request};
            alt_prev   <= {alt_request_one, alt_request_zero};
        end
    end

    // ****************************************
    // Request sources per level
    // ****************************************
    // Level inputs re-arm while held; edge inputs fire once per fall
    always_comb begin
        raw = '0;
        raw[LV_PD]   = POWER_DOWN_REQ;
        raw[LV_E2]   = ctrl[CTL_E2EDGE] ?
                       (ext_request_two & ~upper_prev[3]) :
                       ext_request_two;
        raw[LV_L1]   = level_request_one;
        raw[LV_L0]   = level_request_zero;
        raw[LV_S0TX] = SERIAL_PORT_ZERO_TX_REQ;
        raw[LV_S0RX] = SERIAL_PORT_ZERO_RX_REQ;
        raw[LV_EDGE] = edge_request & ~upper_prev[0];
        raw[LV_BYTE_DMA_PORT] = BYTE_DMA_PORT_REQ;
        raw[LV_TMR]  = TIMER_REQ;
        // Serial port one pins may be retasked at any time
        if (ctrl[CTL_ALT]) begin
            raw[LV_S1TX] = ctrl[CTL_A1EDGE] ?
                           (alt_request_one & ~alt_prev[1]) :
                           alt_request_one;
            raw[LV_S1RX] = ctrl[CTL_A0EDGE] ?
                           (alt_request_zero & ~alt_prev[0]) :
                           alt_request_zero;
        end else begin
            raw[LV_S1TX] = SERIAL_PORT_ONE_TX_REQ;
            raw[LV_S1RX] = SERIAL_PORT_ONE_RX_REQ;
        end
    end

    // Software requests and clears, one-cycle strobes
    always_comb begin
        force_set = '0;
        clr_hit   = '0;
        if (wr && WB_ADR_I == OFS_FORCE) begin
            force_set = WB_DAT_I[NUM_LVL-1:0];
        end
        if (wr && WB_ADR_I == OFS_CLR) begin
            clr_hit = WB_DAT_I[NUM_LVL-1:0];
        end
        if (wr && WB_ADR_I == OFS_VEC && next_hit) begin
            clr_hit[next_level] = 1'b1;
        end
    end

    // ****************************************
    // Sticky status, mask and control
    // ****************************************
    // A new request in the clear cycle survives: set beats clear
    always_ff @(posedge CLK) begin
        if (RST) begin
            status <= '0;
        end else begin
            status <= (status & ~clr_hit) | raw | force_set;
        end
    end

    // Power-down bit stays set: it cannot be masked
    always_ff @(posedge CLK) begin
        if (RST) begin
            interrupt_mask_reg <= MASK_RST;
        end else if (wr && WB_ADR_I == OFS_MASK) begin
            interrupt_mask_reg <= NUM_LVL'(merge(32'(interrupt_mask_reg)))
                                  | MASK_RST;
        end
    end

    // Control; hardware ends idle when an unmasked request appears
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl <= CTRL_RST;
        end else begin
            if (wr && WB_ADR_I == OFS_CTRL) begin
                ctrl <= CTL_W'(merge(32'(ctrl)));
            end
            if (|eff) begin
                ctrl[CTL_IDLE] <= 1'b0;
            end
        end
    end

    // Software mode status, cleared by every reset
    always_ff @(posedge CLK) begin
        if (RST) begin
            mode_status_reg <= MODE_RST;
        end else if (wr && WB_ADR_I == OFS_MODE) begin
            mode_status_reg <= 8'(merge(32'(mode_status_reg)));
        end
    end

    // Mode pins captured only while reset is held
    always_ff @(posedge CLK) begin
        if (RST) begin
            boot_cfg <= low_sync;
        end
    end

    // Pin C high selects host operation for the whole run
    assign HOST_MODE = boot_cfg[MODE_HOST];

    // Flag outputs and directions
    always_ff @(posedge CLK) begin
        if (RST) begin
            flag_reg <= 16'h0000;
        end else if (wr && WB_ADR_I == OFS_FLAG) begin
            flag_reg <= 16'(merge(32'(flag_reg)));
        end
    end

    // Mode pins are never driven during reset so they can be read
    assign FLAG_LINE_OUT       = flag_reg[2:0];
    assign FLAG_LINE_OE        = RST ? 3'h0 :
                                 flag_reg[FLG_DIR+2:FLG_DIR];
    assign UPPER_FLAG_PINS_OUT = flag_reg[FLG_N-1:3];
    assign UPPER_FLAG_PINS_OE  = flag_reg[FLG_DIR+FLG_N-1:FLG_DIR+3];

    // ****************************************
    // Nesting stack depth
    // ****************************************
    // Taking the vector pushes, a write to the nest offset pops
    always_ff @(posedge CLK) begin
        if (RST) begin
            nest <= '0;
        end else if (wr && WB_ADR_I == OFS_VEC && next_hit &&
                     nest != NW'(NEST_DEPTH)) begin
            nest <= nest + NW'(1);
        end else if (wr && WB_ADR_I == OFS_NEST && nest != '0) begin
            nest <= nest - NW'(1);
        end
    end

    // ****************************************
    // Prioritisation and vectoring
    // ****************************************
    // Servicing needs the global enable, except for power-down
    assign eff  = status & interrupt_mask_reg;
    assign pend = ctrl[CTL_GIE] ? eff :
                  (eff & NUM_LVL'(1 << LV_PD));

    // Lowest index wins: fixed internal priority
    always_comb begin
        next_hit   = 1'b0;
        next_level = 4'h0;
        for (int i = NUM_LVL - 1; i >= 0; i--) begin
            if (pend[i]) begin
                next_hit   = 1'b1;
                next_level = 4'(i);
            end
        end
    end

    // Power-up vector control redirects power-down exit to reset
    always_comb begin
        next_vector = VEC_TBL[next_level];
        if (next_level == 4'(LV_PD) && ctrl[CTL_POWERUP_VECTOR_CONTROL]) begin
            next_vector = VEC_RESET;
        end
        if (!next_hit) begin
            next_vector = VEC_RESET;
        end
    end

    // Registered vector outputs; reset shows the reset vector
    always_ff @(posedge CLK) begin
        if (RST) begin
            IRQ    <= 1'b0;
            VECTOR <= VEC_RESET;
            LEVEL  <= 4'h0;
        end else begin
            IRQ    <= next_hit;
            VECTOR <= next_vector;
            LEVEL  <= next_level;
        end
    end

    assign IDLE = ctrl[CTL_IDLE];

    // ****************************************
    // Read path
    // ****************************************
    // Unmapped offsets read zero and still acknowledge
    always_comb begin
        rd_data = 32'h0000_0000;
        case (WB_ADR_I)
            OFS_MASK:  rd_data = 32'(interrupt_mask_reg);
            OFS_CTRL:  rd_data = 32'(ctrl);
            OFS_STAT:  rd_data = 32'(status);
            OFS_VEC:   rd_data = {12'h000, next_level, next_vector};
            OFS_MODE:  rd_data = 32'(mode_status_reg);
            OFS_CFG:   rd_data = 32'(boot_cfg);
            OFS_FLAG:  rd_data = {16'h0000, flag_reg[15:8], 1'b0,
                                  upper_sync, low_sync};
            OFS_NEST:  rd_data = 32'(nest);
            default:   rd_data = 32'h0000_0000;
        endcase
    end

    // One wait state: ack and data one edge after the request
    always_ff @(posedge CLK) begin
        if (RST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= acc;
            if (rd_unused) begin
                WB_DAT_O <= rd_data;
            end
        end
    end

endmodule : mcic_top

// [inc/mcic_pkg.sv]
// Functional notes
// - Eleven interrupt sources plus reset are handled per processor.
// - Four external requests share pins with the upper four flag lines.
// - Timer, byte DMA, serial ports, software and power-down can request.
// - Fixed priorities; all maskable except power-down and reset.
// - Ext two and alternate requests pick edge or level; others fixed.
// - Reset vectors to 0000, and power-up does too when its bit is one.
// - Priority runs from power-down down to the timer, vector 0028 last.
// - Levels one to seven vector to 0004 through 001C as tabled.
// - Serial port one and the alternate requests share 0020 and 0024.
// - Reset disables servicing of all but power-down until software enables it.
// - A shared pin interrupts whether driven outside or as a flag.
// - Mode pins are sampled only in reset and are flags afterwards.
// - Software selects serial port one pins as alternate requests.
// - Reset masks all but power-down, empties the stack, clears mode status.
// - An unmasked interrupt ends idle so execution can carry on.
package mcic_pkg;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] OFS_MASK  = 8'h00;
    localparam logic [7:0] OFS_CTRL  = 8'h04;
    localparam logic [7:0] OFS_STAT  = 8'h08;
    localparam logic [7:0] OFS_CLR   = 8'h0C;
    localparam logic [7:0] OFS_FORCE = 8'h10;
    localparam logic [7:0] OFS_VEC   = 8'h14;
    localparam logic [7:0] OFS_MODE  = 8'h18;
    localparam logic [7:0] OFS_CFG   = 8'h1C;
    localparam logic [7:0] OFS_FLAG  = 8'h20;
    localparam logic [7:0] OFS_NEST  = 8'h24;

    // ****************************************
    // Interrupt levels, index equals priority
    // ****************************************
    localparam int NUM_LVL = 11;
    localparam int LV_PD   = 0;
    localparam int LV_E2   = 1;
    localparam int LV_L1   = 2;
    localparam int LV_L0   = 3;
    localparam int LV_S0TX = 4;
    localparam int LV_S0RX = 5;
    localparam int LV_EDGE = 6;
    localparam int LV_BYTE_DMA_PORT = 7;
    localparam int LV_S1TX = 8;
    localparam int LV_S1RX = 9;
    localparam int LV_TMR  = 10;

    // Vector table, entry per level
    localparam logic [15:0] VEC_RESET = 16'h0000;
    localparam logic [NUM_LVL-1:0][15:0] VEC_TBL = '{
        16'h0028, 16'h0024, 16'h0020, 16'h001C, 16'h0018, 16'h0014,
        16'h0010, 16'h000C, 16'h0008, 16'h0004, 16'h002C};

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int CTL_GIE    = 0;
    localparam int CTL_ALT    = 1;
    localparam int CTL_POWERUP_VECTOR_CONTROL   = 2;
    localparam int CTL_E2EDGE = 3;
    localparam int CTL_A1EDGE = 4;
    localparam int CTL_A0EDGE = 5;
    localparam int CTL_IDLE   = 6;
    localparam int CTL_W      = 7;
    localparam logic [CTL_W-1:0] CTRL_RST = 7'h00;

    // Flag register: outputs low byte, directions high byte
    localparam int FLG_N     = 7;
    localparam int FLG_DIR   = 8;
    localparam int MODE_HOST = 2;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [NUM_LVL-1:0] MASK_RST = 11'h001;

endpackage : mcic_pkg

// [rtl/mcic_sync.sv]
`timescale 1ns/1ps
// ****************************************
// Three-stage pin synchroniser
// ****************************************
module mcic_sync #(
    parameter int W = 1
) (
    // Clock
    input  wire logic         clk,
    // Pins and clean copy
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // No reset here, so mode pins stay visible while reset is held
    always_ff @(posedge clk) begin
        s1 <= d;
        s2 <= s1;
        s3 <= s2;
    end

    // A change counts once stages two and three agree
    genvar i;
    for (i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk) begin
            if (s2[i] == s3[i]) begin
                q[i] <= s3[i];
            end
        end
    end
endmodule : mcic_sync

// [sim/mcic_props.sv]
`timescale 1ns/1ps
// ****************************************
// Port checker for the interrupt controller
// ****************************************
module mcic_props
    import mcic_pkg::*;
(
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RST,
    // Bus handshake
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_ACK_O,
    // Requests and sequencer side
    input wire logic        POWER_DOWN_REQ,
    input wire logic        IRQ,
    input wire logic [15:0] VECTOR,
    input wire logic [3:0]  LEVEL,
    input wire logic        IDLE,
    input wire logic        HOST_MODE,
    input wire logic [2:0]  FLAG_LINE_OE
);
    default clocking cb @(posedge CLK);
    endclocking

    // Bus answers exactly one cycle after a taken request
    a_ack_after_take: assert property (disable iff (RST)
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack missing one cycle after request");
    a_ack_one_pulse: assert property (disable iff (RST)
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");
    // Reset leaves nothing to service
    a_reset_quiet: assert property (
        RST |=> !IRQ && VECTOR == 16'h0000 && LEVEL == 4'h0)
        else $error("request shown after reset");
    a_mode_pins_free: assert property (
        RST |=> FLAG_LINE_OE == 3'h0)
        else $error("mode pins driven during reset");
    // Power-down answers without any mask or enable
    a_pd_answer: assert property (disable iff (RST)
        POWER_DOWN_REQ |-> ##[1:2] IRQ && LEVEL == 4'h0)
        else $error("power-down request not answered");
    a_vec_table: assert property (disable iff (RST)
        IRQ && LEVEL != 4'h0 |-> VECTOR == VEC_TBL[LEVEL])
        else $error("vector does not match level");
    a_pd_vector: assert property (disable iff (RST)
        IRQ && LEVEL == 4'h0 |-> VECTOR inside {16'h002C, 16'h0000})
        else $error("power-down vector wrong");
    a_level_range: assert property (disable iff (RST)
        IRQ |-> LEVEL <= 4'd10)
        else $error("level index out of range");
    // Host mode only moves while reset is held
    a_host_fixed: assert property (disable iff (RST)
        !$past(RST) |-> $stable(HOST_MODE))
        else $error("host mode changed while running");
    // A serviceable request ends idle
    a_idle_wakes: assert property (disable iff (RST)
        IRQ |-> ##[0:1] !IDLE)
        else $error("idle kept with request pending");

    // Main scenarios
    c_timer: cover property (disable iff (RST) IRQ && LEVEL == 4'd10);
    c_pd_zero: cover property (disable iff (RST) IRQ && VECTOR == 16'h0);
    c_wake: cover property (disable iff (RST) $fell(IDLE));
endmodule : mcic_props

bind mcic_top mcic_props u_props (
    .CLK(CLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_ACK_O(WB_ACK_O), .POWER_DOWN_REQ(POWER_DOWN_REQ), .IRQ(IRQ),
    .VECTOR(VECTOR), .LEVEL(LEVEL), .IDLE(IDLE), .HOST_MODE(HOST_MODE),
    .FLAG_LINE_OE(FLAG_LINE_OE));

// [sim/mcic_src.sv]
`timescale 1ns/1ps
// ****************************************
// Pins and on-chip request sources
// ****************************************
module mcic_src (
    // Clock
    input  wire logic       clk,
    // Bench commands
    input  wire logic [6:0] fire,
    input  wire logic [3:0] ext_low,
    input  wire logic [2:0] strap,
    // Design pin drivers
    input  wire logic [3:0] up_out,
    input  wire logic [3:0] up_oe,
    input  wire logic [2:0] fl_out,
    input  wire logic [2:0] fl_oe,
    // Toward the design
    output logic      [3:0] up_pin,
    output logic      [2:0] fl_pin,
    output logic      [6:0] req
);
    // Pulled-up shared pins: device or flag driver may pull low
    assign up_pin = ~ext_low & (up_oe & up_out | ~up_oe);
    // Straps act as the pulls once the flag driver lets go
    assign fl_pin = fl_oe & fl_out | ~fl_oe & strap;
    // Peripherals give one clean pulse per event, clock aligned
    always_ff @(posedge clk) begin
        req <= fire;
    end
endmodule : mcic_src

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench
    import mcic_pkg::*;
;
    logic        clk, rst, cyc, stb, we, ack, irq, idle, host;
    logic        alt1_n;
    logic [7:0]  adr;
    logic [31:0] dwr, rdat;
    logic [3:0]  up_in, up_out, up_oe, ext_low, lvl;
    logic [2:0]  fl_in, fl_out, fl_oe, strap;
    logic [6:0]  fire, req;
    logic [15:0] vec;
    int          error_cnt, cmp_count, cycles;
    // Vector expected per level, highest priority first
    logic [15:0] exp_vec [11] = '{16'h002C, 16'h0004, 16'h0008, 16'h000C,
        16'h0010, 16'h0014, 16'h0018, 16'h001C, 16'h0020, 16'h0024, 16'h0028};

    mcic_top dut (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dwr),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .UPPER_FLAG_PINS_IN(up_in),
        .UPPER_FLAG_PINS_OUT(up_out), .UPPER_FLAG_PINS_OE(up_oe),
        .FLAG_LINE_IN(fl_in), .FLAG_LINE_OUT(fl_out), .FLAG_LINE_OE(fl_oe),
        .ALT_REQUEST_ONE_N(alt1_n), .ALT_REQUEST_ZERO_N(1'b1),
        .TIMER_REQ(req[0]), .BYTE_DMA_PORT_REQ(req[1]),
        .SERIAL_PORT_ZERO_TX_REQ(req[2]), .SERIAL_PORT_ZERO_RX_REQ(req[3]),
        .SERIAL_PORT_ONE_TX_REQ(req[4]), .SERIAL_PORT_ONE_RX_REQ(req[5]),
        .POWER_DOWN_REQ(req[6]), .IRQ(irq), .VECTOR(vec), .LEVEL(lvl),
        .IDLE(idle), .HOST_MODE(host));
    mcic_src u_src (.clk(clk), .fire(fire), .ext_low(ext_low),
        .strap(strap), .up_out(up_out), .up_oe(up_oe), .fl_out(fl_out),
        .fl_oe(fl_oe), .up_pin(up_in), .fl_pin(fl_in), .req(req));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // Classic cycle: hold everything until ack is sampled
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dwr <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check(nm, q, e);
    endtask : rdc
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic pulse(input logic [6:0] f);
        @(posedge clk);
        fire <= f;
        @(posedge clk);
        fire <= 7'h00;
    endtask : pulse
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    // ****************************************
    // Clock and hang guard
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Whole run needs under four hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        {rst, cyc, stb, we, adr, dwr} = {3'b100, 1'b0, 8'h00, 32'h0};
        {fire, ext_low, alt1_n, strap} = {7'h00, 4'h0, 1'b1, 3'b101};
        tick(10);
        rst <= 1'b0;
        tick(2);
        check("host", host, 1);
        check("irq", irq, 0);
        rdc("mask", OFS_MASK, 32'h1);
        rdc("ctrl", OFS_CTRL, 32'h0);
        rdc("status", OFS_STAT, 32'h0);
        rdc("mode_status_reg", OFS_MODE, 32'h0);
        rdc("nest", OFS_NEST, 32'h0);
        rdc("unmapped", 8'h3C, 32'h0);
        // Straps move after reset: captured mode stays, lines are flags
        strap <= 3'b000;
        tick(8);
        rdc("modepins", OFS_CFG, 32'h5);
        rdc("flags", OFS_FLAG, 32'h78);
        check("host", host, 1);
        wr(OFS_MODE, 32'hA5);
        rdc("mode_status_reg", OFS_MODE, 32'hA5);
        // Every level at once, served strictly by priority
        wr(OFS_CTRL, 32'h1);
        wr(OFS_MASK, 32'h7FF);
        wr(OFS_FORCE, 32'h7FF);
        for (int n = 0; n < 11; n++) begin
            tick(2);
            check("irq", irq, 1);
            check("level", lvl, n);
            check("vector", vec, exp_vec[n]);
            wr(OFS_CLR, 32'h1 << n);
        end
        tick(2);
        check("irq", irq, 0);
        // Masked timer waits in status; servicing off blocks it too
        wr(OFS_MASK, 32'h1);
        pulse(7'h01);
        tick(3);
        check("irq", irq, 0);
        rdc("status", OFS_STAT, 32'h400);
        wr(OFS_CTRL, 32'h0);
        wr(OFS_MASK, 32'h401);
        tick(3);
        check("irq", irq, 0);
        pulse(7'h40);
        tick(3);
        check("pd", vec, 16'h002C);
        wr(OFS_CTRL, 32'h4);
        tick(2);
        check("pd", vec, 16'h0000);
        wr(OFS_CLR, 32'h1);
        wr(OFS_CTRL, 32'h1);
        tick(2);
        check("timer", vec, 16'h0028);
        wr(OFS_CLR, 32'h400);
        // Edge pin sets once, level pin keeps setting
        wr(OFS_MASK, 32'h7FF);
        ext_low <= 4'h1;
        tick(8);
        wr(OFS_CLR, 32'h40);
        tick(2);
        rdc("edge", OFS_STAT, 32'h0);
        ext_low <= 4'h4;
        tick(8);
        wr(OFS_CLR, 32'h4);
        tick(2);
        rdc("level", OFS_STAT, 32'h4);
        // Ext two in edge mode sets once while held low
        wr(OFS_CTRL, 32'h9);
        ext_low <= 4'h8;
        tick(8);
        wr(OFS_CLR, 32'h6);
        tick(2);
        rdc("edge two", OFS_STAT, 32'h0);
        wr(OFS_CTRL, 32'h1);
        ext_low <= 4'h0;
        tick(8);
        wr(OFS_CLR, 32'h7FF);
        // Own flag output pulls the ext two pin
        wr(OFS_FLAG, 32'h4705);
        tick(8);
        check("flag oe", {up_oe, up_out}, 8'h80);
        check("low flags", {fl_oe, fl_out}, 6'h3D);
        check("vector", vec, 16'h0004);
        rdc("flag read", OFS_FLAG, 32'h473D);
        wr(OFS_FLAG, 32'h0);
        tick(8);
        wr(OFS_CLR, 32'h7FF);
        // Alternate request counts only once selected
        alt1_n <= 1'b0;
        tick(8);
        rdc("alt off", OFS_STAT, 32'h0);
        wr(OFS_CTRL, 32'h3);
        tick(8);
        check("alt", vec, 16'h0020);
        alt1_n <= 1'b1;
        tick(8);
        wr(OFS_CLR, 32'h7FF);
        // Alternate request one in edge mode sets once
        wr(OFS_CTRL, 32'h13);
        alt1_n <= 1'b0;
        tick(8);
        wr(OFS_CLR, 32'h100);
        tick(2);
        rdc("alt edge", OFS_STAT, 32'h0);
        alt1_n <= 1'b1;
        // Idle ends on an unmasked request; take pushes the nest
        wr(OFS_CTRL, 32'h41);
        tick(2);
        check("idle", idle, 1);
        pulse(7'h01);
        tick(3);
        check("idle", idle, 0);
        wr(OFS_VEC, 32'h0);
        rdc("nest", OFS_NEST, 32'h1);
        // Reset in mid-run with a request pending
        pulse(7'h02);
        rst <= 1'b1;
        tick(6);
        rst <= 1'b0;
        tick(2);
        check("irq", irq, 0);
        rdc("mask", OFS_MASK, 32'h1);
        rdc("ctrl", OFS_CTRL, 32'h0);
        rdc("nest", OFS_NEST, 32'h0);
        rdc("mode_status_reg", OFS_MODE, 32'h0);
        check("host", host, 0);
        complete_run();
    end
endmodule : testbench
